// File: bench/pcr_power_ctrl_asserts.sv
// Purpose: Port-level checks of the power, clock and reset controller.
// Assumes: One aclk domain; aresetn synchronous, active low.
// Notes: Bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module pcr_power_ctrl_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [2:0] dma_grant,
	input wire logic core_tick,
	input wire logic serial_clock_tick,
	input wire logic timer_tick,
	input wire logic cycle_clock_output,
	input wire logic power_down_irq,
	input wire logic power_down_ack,
	input wire logic context_restore,
	input wire logic context_clear_pulse,
	input wire logic stack_reset,
	input wire logic fetch_start,
	input wire logic [13:0] fetch_addr,
	input wire logic memory_mode
);
	// ==========================================================
	// Checks
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Recovery takes 400 cycles after the acknowledge falls; the bound leaves 20 spare
	sequence s_resume;
		##[1:420] (context_restore || context_clear_pulse);
	endsequence
	AST_WAKE_BOUND: assert property ($fell(power_down_ack) |-> s_resume)
		else $error("no resume after leaving power-down");
	AST_DORMANT_NO_GRANT: assert property (power_down_ack |-> dma_grant == 3'h0)
		else $error("grant while dormant");
	AST_TICKS_TIED: assert property (serial_clock_tick == core_tick && timer_tick == core_tick)
		else $error("derived ticks differ from core tick");
	AST_CYCLE_CLOCK_OUTPUT_ON_TICK: assert property (!$past(core_tick) |-> $stable(cycle_clock_output) || !cycle_clock_output)
		else $error("clock output moved without a tick");
	AST_IRQ_PULSE: assert property (power_down_irq |=> !power_down_irq)
		else $error("power-down interrupt longer than one cycle");
	AST_FETCH_ZERO: assert property (fetch_start |-> fetch_addr == 14'h0000)
		else $error("first fetch not at address zero");
	AST_MODE_HELD: assert property ($past(aresetn) |-> $stable(memory_mode))
		else $error("memory mode changed outside reset");
	AST_STACK_RESET: assert property ($rose(aresetn) |-> $past(stack_reset) && !stack_reset)
		else $error("stack reset does not follow master reset");
	AST_RESET_ENDS_SLEEP: assert property ($rose(aresetn) |-> !power_down_ack && !power_down_irq)
		else $error("power-down state survived reset");
endmodule // pcr_power_ctrl_asserts
`default_nettype wire

// File: bench/pcr_power_ctrl_tb.sv
// Purpose: Self-checking bench for the power, clock and reset controller.
// Assumes: CRYSTAL_WAIT shortened to 16 cycles; pins come from the controller model.
// Notes: Tests are AXI4-Lite calls and bounded waits on outputs.
`timescale 1ns/1ps
`default_nettype none
module pcr_power_ctrl_tb;
	localparam int XW = 16;
	logic aclk = 1'b0;
	logic aresetn, sleep_n, bus_n, flag2, awready, wready, bvalid, arready, rvalid;
	logic reset_req = 1'b0;
	logic sleep_req = 1'b0;
	logic mode_level = 1'b1;
	logic [7:0] awaddr = 8'h00;
	logic [7:0] araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [1:0] bresp, rresp;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic boot_enable = 1'b1;
	logic boot_done = 1'b0;
	logic [7:0] irq_request = 8'h00;
	logic [2:0] dma_request = 3'h0;
	logic [2:0] dma_grant;
	logic core_tick, serial_clock_tick, timer_tick, cycle_clock_output, power_down_irq;
	logic power_down_ack, context_restore, context_clear_pulse, stack_reset, boot_start;
	logic fetch_start, memory_mode;
	logic [13:0] fetch_addr;
	int bad_count = 0;
	int n_compared = 0;
	int cycles = 0;
	always #2.5 aclk = ~aclk;
	pcr_sysctl_model #(.HOLD(3)) i_pcr_sysctl_model (.aclk(aclk), .reset_req(reset_req),
		.sleep_req(sleep_req), .mode_level(mode_level), .aresetn(aresetn),
		.sleep_request_pin_n(sleep_n), .bus_request_pin_n(bus_n), .flag_pin_two(flag2));
	pcr_power_ctrl #(.CRYSTAL_WAIT(XW), .IRQ_W(8)) i_pcr_power_ctrl (.aclk(aclk),
		.aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.sleep_request_pin_n(sleep_n), .flag_pin_two(flag2), .bus_request_pin_n(bus_n),
		.boot_enable(boot_enable), .boot_done(boot_done), .irq_request(irq_request),
		.dma_request(dma_request), .dma_grant(dma_grant), .core_tick(core_tick),
		.serial_clock_tick(serial_clock_tick), .timer_tick(timer_tick),
		.cycle_clock_output(cycle_clock_output), .power_down_irq(power_down_irq),
		.power_down_ack(power_down_ack), .context_restore(context_restore),
		.context_clear_pulse(context_clear_pulse), .stack_reset(stack_reset),
		.boot_start(boot_start), .fetch_start(fetch_start), .fetch_addr(fetch_addr),
		.memory_mode(memory_mode));
	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	function automatic logic pick(input int s);
		case (s)
			0: pick = power_down_irq;
			1: pick = power_down_ack;
			2: pick = context_restore;
			3: pick = context_clear_pulse;
			4: pick = fetch_start;
			5: pick = boot_start;
			6: pick = core_tick;
			default: pick = cycle_clock_output;
		endcase
	endfunction
	task automatic wait_on(input int s, input int lim, input logic e, output int n);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (pick(s) !== 1'b1 && n < lim);
		check(32'(pick(s)), 32'(e));
	endtask
	// Waits as long as the slave needs; only the bench timeout ends a hang
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		check(32'(bresp), 32'(pcr_pkg::RESP_OKAY));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		check(rdata & m, e);
		check(32'(rresp), 32'(er));
	endtask
	// ==========================================================
	// Tests
	initial begin
		int n;
		int k;
		int d;
		wait_on(5, 100, 1'b1, n);
		repeat (4) @(posedge aclk);
		check(32'(fetch_start), 32'h0);
		boot_done <= 1'b1;
		wait_on(4, 20, 1'b1, n);
		rd(pcr_pkg::CTRL_OFS, 32'h3F, 32'h20, pcr_pkg::RESP_OKAY);
		rd(pcr_pkg::MODE_STATUS_OFS, 32'hFFFF, 32'h0, pcr_pkg::RESP_OKAY);
		rd(8'h14, 32'hFFFFFFFF, 32'h0, pcr_pkg::RESP_SLVERR);
		rd(pcr_pkg::STATUS_OFS, 32'h47, 32'h41, pcr_pkg::RESP_OKAY);
		wr(pcr_pkg::CTRL_OFS, 32'h30);
		wait_on(7, 8, 1'b0, n);
		wr(pcr_pkg::CTRL_OFS, 32'h20);
		wait_on(7, 8, 1'b1, n);
		@(posedge aclk);
		check(32'(cycle_clock_output), 32'h0);
		dma_request <= 3'h7;
		wr(pcr_pkg::MASK_OFS, 32'h1);
		wr(pcr_pkg::MODE_STATUS_OFS, 32'hA5C3);
		rd(pcr_pkg::MODE_STATUS_OFS, 32'hFFFF, 32'hA5C3, pcr_pkg::RESP_OKAY);
		// Code 0 is plain idle, codes 1 to 4 divide by 16 to 128
		for (k = 0; k < 5; k++) begin
			d = (k == 0) ? 1 : 8 << k;
			wr(pcr_pkg::IDLE_OFS, 32'(k));
			rd(pcr_pkg::STATUS_OFS, 32'h7, 32'h2, pcr_pkg::RESP_OKAY);
			check(32'(dma_grant), 32'h7);
			irq_request <= 8'h02;
			if (k > 0) begin
				wait_on(6, 300, 1'b1, n);
				wait_on(6, 300, 1'b1, n);
				check(32'(n), 32'(d));
			end
			rd(pcr_pkg::STATUS_OFS, 32'h7, 32'h2, pcr_pkg::RESP_OKAY);
			irq_request <= 8'h03;
			repeat (d + 2) @(posedge aclk); // Request outlasts the slowed wake
			irq_request <= 8'h00;
			rd(pcr_pkg::STATUS_OFS, 32'h7, 32'h1, pcr_pkg::RESP_OKAY);
		end
		sleep_req <= 1'b1;
		wait_on(0, 50, 1'b1, n);
		wr(pcr_pkg::CTRL_OFS, 32'h22);
		wait_on(1, 20, 1'b1, n);
		rd(pcr_pkg::STATUS_OFS, 32'hF, 32'hB, pcr_pkg::RESP_OKAY);
		sleep_req <= 1'b0;
		wait_on(2, 420, 1'b1, n);
		check(32'(power_down_ack), 32'h0);
		wr(pcr_pkg::CTRL_OFS, 32'h21);
		wait_on(0, 20, 1'b1, n);
		rd(pcr_pkg::CTRL_OFS, 32'h3F, 32'h21, pcr_pkg::RESP_OKAY);
		wr(pcr_pkg::CTRL_OFS, 32'h2E);
		wait_on(3, XW + 20, 1'b1, n);
		check(32'(n >= XW), 32'h1);
		// Interrupts off must hold the request pending, not drop it
		wr(pcr_pkg::CTRL_OFS, 32'h00);
		sleep_req <= 1'b1;
		wait_on(0, 40, 1'b0, n);
		rd(pcr_pkg::STATUS_OFS, 32'h20, 32'h20, pcr_pkg::RESP_OKAY);
		wr(pcr_pkg::CTRL_OFS, 32'h22);
		wait_on(1, 20, 1'b1, n);
		mode_level <= 1'b0;
		sleep_req <= 1'b0;
		reset_req <= 1'b1;
		@(posedge aclk);
		reset_req <= 1'b0;
		repeat (3) @(posedge aclk);
		check(32'(power_down_ack), 32'h0);
		wait_on(4, 60, 1'b1, n);
		rd(pcr_pkg::MODE_STATUS_OFS, 32'hFFFF, 32'h0, pcr_pkg::RESP_OKAY);
		rd(pcr_pkg::MASK_OFS, 32'hFF, 32'h0, pcr_pkg::RESP_OKAY);
		rd(pcr_pkg::STATUS_OFS, 32'h47, 32'h01, pcr_pkg::RESP_OKAY);
		results();
	end
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			results();
		end
	end
endmodule // pcr_power_ctrl_tb
bind pcr_power_ctrl pcr_power_ctrl_asserts i_pcr_power_ctrl_asserts (.aclk(aclk),
	.aresetn(aresetn), .dma_grant(dma_grant), .core_tick(core_tick),
	.serial_clock_tick(serial_clock_tick), .timer_tick(timer_tick),
	.cycle_clock_output(cycle_clock_output), .power_down_irq(power_down_irq),
	.power_down_ack(power_down_ack), .context_restore(context_restore),
	.context_clear_pulse(context_clear_pulse), .stack_reset(stack_reset),
	.fetch_start(fetch_start), .fetch_addr(fetch_addr), .memory_mode(memory_mode));
`default_nettype wire

// File: bench/pcr_sysctl_model.sv
// Purpose: System controller model for reset, sleep, bus request and mode pins.
// Assumes: Pins change just after a rising aclk edge.
// Notes: The flag pin toggles after reset, as a flag output would.
`timescale 1ns/1ps
`default_nettype none
module pcr_sysctl_model #(
	parameter int HOLD = 4
) (
	input wire logic aclk,
	input wire logic reset_req,
	input wire logic sleep_req,
	input wire logic mode_level,
	output logic aresetn,
	output logic sleep_request_pin_n,
	output logic bus_request_pin_n,
	output logic flag_pin_two
);
	int cnt = HOLD;
	initial begin
		aresetn = 1'b0;
		sleep_request_pin_n = 1'b1;
		bus_request_pin_n = 1'b0;
		flag_pin_two = mode_level;
	end
	// Short hold stands in for the long power-up hold to keep the run brief
	always @(posedge aclk) begin
		cnt <= reset_req ? HOLD : (cnt == 0 ? 0 : cnt - 1);
		aresetn <= cnt == 0 && !reset_req;
		bus_request_pin_n <= aresetn;
		sleep_request_pin_n <= !sleep_req;
		flag_pin_two <= (cnt == 0 && !reset_req) ? !flag_pin_two : mode_level;
	end
endmodule // pcr_sysctl_model
`default_nettype wire

// File: rtl/pcr_pkg.sv
// Purpose: Shared constants and types for the power, clock and reset control block.
// Assumes: aclk at 200 MHz stands for the processor cycle clock.
// Notes: Byte offsets of the AXI4-Lite register map.
package pcr_pkg;
	// ==========================================================
	// Register map
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] IDLE_OFS = 8'h04;
	localparam logic [7:0] STATUS_OFS = 8'h08;
	localparam logic [7:0] MASK_OFS = 8'h0C;
	localparam logic [7:0] MODE_STATUS_OFS = 8'h10;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ==========================================================
	// Field positions
	localparam int CTRL_FORCE_BIT = 0;
	localparam int CTRL_COMMIT_BIT = 1;
	localparam int CTRL_CLEAR_BIT = 2;
	localparam int CTRL_CRYSTAL_OFF_BIT = 3;
	localparam int CTRL_CKODIS_BIT = 4;
	localparam int CTRL_GIE_BIT = 5;
	localparam logic [5:0] CTRL_RESET = 6'h20;
	localparam logic [7:0] MASK_RESET = 8'h00;
	localparam logic [15:0] MODE_STATUS_RESET = 16'h0000;
	localparam logic [13:0] FIRST_FETCH_ADDR = 14'h0000;
	// ==========================================================
	// Slow idle divisor codes
	localparam logic [2:0] DIV_NONE = 3'h0;
	localparam logic [2:0] DIV_16 = 3'h1;
	localparam logic [2:0] DIV_32 = 3'h2;
	localparam logic [2:0] DIV_64 = 3'h3;
	localparam logic [2:0] DIV_128 = 3'h4;
	// ==========================================================
	// Timing: input clock runs at half the cycle rate
	localparam int CYCLES_PER_INPUT_CLOCK = 2;
	localparam int RECOVER_INPUT_CLOCKS = 200;
	localparam int RECOVER_CYCLES = RECOVER_INPUT_CLOCKS * CYCLES_PER_INPUT_CLOCK;
	localparam int CRYSTAL_START_INPUT_CLOCKS = 4096;
	localparam int CRYSTAL_START_CYCLES = CRYSTAL_START_INPUT_CLOCKS * CYCLES_PER_INPUT_CLOCK;
	// ==========================================================
	// States
	typedef enum logic [2:0] {
		PCR_BOOT = 3'b000,
		PCR_RUN = 3'b001,
		PCR_IDLE = 3'b010,
		PCR_DORMANT = 3'b011,
		PCR_WAKE = 3'b100
	} pcr_state_t;
	typedef struct packed {
		logic global_int_enable;
		logic clock_output_disable;
		logic crystal_off;
		logic context_clear;
		logic commit;
		logic sleep_force;
	} pcr_ctrl_t;
endpackage

// File: rtl/pcr_power_ctrl.sv
// Purpose: Low-power states, cycle clock gating, master reset and boot start of a DSP core.
// Assumes: aclk is the processor cycle clock; pins are asynchronous and synchronised here.
// Notes: Registers over AXI4-Lite; one write and one read outstanding at most.
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module pcr_power_ctrl #(
	parameter int CRYSTAL_WAIT = pcr_pkg::CRYSTAL_START_CYCLES,
	parameter int IRQ_W = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sleep_request_pin_n,
	input wire logic flag_pin_two,
	input wire logic bus_request_pin_n,
	input wire logic boot_enable,
	input wire logic boot_done,
	input wire logic [IRQ_W-1:0] irq_request,
	input wire logic [2:0] dma_request,
	output logic [2:0] dma_grant,
	output logic core_tick,
	output logic serial_clock_tick,
	output logic timer_tick,
	output logic cycle_clock_output,
	output logic power_down_irq,
	output logic power_down_ack,
	output logic context_restore,
	output logic context_clear_pulse,
	output logic stack_reset,
	output logic boot_start,
	output logic fetch_start,
	output logic [13:0] fetch_addr,
	output logic memory_mode
);
	// ==========================================================
	// Helpers
	function automatic logic [7:0] div_count(input logic [2:0] code);
		case (code)
			pcr_pkg::DIV_16: div_count = 8'h0F;
			pcr_pkg::DIV_32: div_count = 8'h1F;
			pcr_pkg::DIV_64: div_count = 8'h3F;
			pcr_pkg::DIV_128: div_count = 8'h7F;
			default: div_count = 8'h00;
		endcase
	endfunction

	localparam logic [13:0] RECOVER_LAST = 14'(pcr_pkg::RECOVER_CYCLES - 1);
	localparam logic [13:0] CRYSTAL_LAST = 14'(CRYSTAL_WAIT - 1);

	pcr_pkg::pcr_state_t state;
	pcr_pkg::pcr_ctrl_t ctrl;
	logic [IRQ_W-1:0] irq_mask;
	logic [15:0] mode_status;
	logic [2:0] div_code;
	logic [7:0] div_cnt;
	logic [13:0] wake_cnt;
	logic [2:0] sleep_sync;
	logic [2:0] mode_sync;
	logic [2:0] busreq_sync;
	logic sleep_level;
	logic sleep_prev;
	logic pd_pending;
	logic pd_event;
	logic pd_serviced;
	logic boot_issued;
	logic wr_addr_held;
	logic wr_data_held;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_go;
	logic wake_irq;

	// ==========================================================
	// Pin synchronisers: a change counts once stages two and three agree
	always_ff @(posedge aclk) begin
		sleep_sync <= {sleep_sync[1:0], sleep_request_pin_n};
		mode_sync <= {mode_sync[1:0], flag_pin_two};
		busreq_sync <= {busreq_sync[1:0], bus_request_pin_n};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sleep_level <= 1'b0;
			sleep_prev <= 1'b0;
		end else begin
			if (sleep_sync[1] == sleep_sync[2]) begin
				sleep_level <= !sleep_sync[2];
			end
			sleep_prev <= sleep_level;
		end
	end

	// Mode pin is caught while reset is held, then the pin is a plain flag
	always_ff @(posedge aclk) begin
		if (!aresetn && mode_sync[1] == mode_sync[2]) begin
			memory_mode <= mode_sync[2];
		end
	end

	// ==========================================================
	// AXI4-Lite write path
	assign s_axi_awready = !wr_addr_held && !s_axi_bvalid;
	assign s_axi_wready = !wr_data_held && !s_axi_bvalid;
	assign wr_go = wr_addr_held && wr_data_held && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wr_addr_held <= 1'b0;
			wr_data_held <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= pcr_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				wr_addr_held <= 1'b1;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wr_data_held <= 1'b1;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (wr_go) begin
				wr_addr_held <= 1'b0;
				wr_data_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_addr[7:2] <= pcr_pkg::MODE_STATUS_OFS[7:2]) ?
					pcr_pkg::RESP_OKAY : pcr_pkg::RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl <= pcr_pkg::CTRL_RESET;
			irq_mask <= IRQ_W'(pcr_pkg::MASK_RESET);
			mode_status <= pcr_pkg::MODE_STATUS_RESET;
		end else begin
			if (wr_go && wr_strb[0] && wr_addr == pcr_pkg::CTRL_OFS) begin
				ctrl <= wr_data[5:0];
			end else if (state == pcr_pkg::PCR_DORMANT) begin
				// Force and commit are one-shot: cleared once dormant
				ctrl.sleep_force <= 1'b0;
				ctrl.commit <= 1'b0;
			end
			if (wr_go && wr_addr == pcr_pkg::MASK_OFS && wr_strb[0]) begin
				irq_mask <= wr_data[IRQ_W-1:0];
			end
			if (wr_go && wr_addr == pcr_pkg::MODE_STATUS_OFS) begin
				if (wr_strb[0]) mode_status[7:0] <= wr_data[7:0];
				if (wr_strb[1]) mode_status[15:8] <= wr_data[15:8];
			end
		end
	end

	// ==========================================================
	// Power-down interrupt: sticky until taken on a core tick, so slow idle still wakes
	assign pd_event = (sleep_level && !sleep_prev) ||
		(wr_go && wr_strb[0] && wr_addr == pcr_pkg::CTRL_OFS &&
		wr_data[pcr_pkg::CTRL_FORCE_BIT] && !ctrl.sleep_force);
	assign pd_serviced = pd_pending && ctrl.global_int_enable && core_tick;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pd_pending <= 1'b0;
			power_down_irq <= 1'b0;
		end else begin
			// A new edge wins over the service of the previous one
			if (pd_event) begin
				pd_pending <= 1'b1;
			end else if (pd_serviced) begin
				pd_pending <= 1'b0;
			end
			power_down_irq <= pd_serviced;
		end
	end

	// ==========================================================
	// Core rate: full rate normally, divided in slow idle
	assign wake_irq = |(irq_request & irq_mask);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_cnt <= 8'h00;
			core_tick <= 1'b0;
		end else begin
			if (state == pcr_pkg::PCR_DORMANT || state == pcr_pkg::PCR_WAKE) begin
				core_tick <= 1'b0;
				div_cnt <= 8'h00;
			end else if (state == pcr_pkg::PCR_IDLE && div_cnt != 8'h00) begin
				div_cnt <= div_cnt - 8'h01;
				core_tick <= 1'b0;
			end else begin
				div_cnt <= (state == pcr_pkg::PCR_IDLE) ? div_count(div_code) : 8'h00;
				core_tick <= 1'b1;
			end
		end
	end

	assign serial_clock_tick = core_tick;
	assign timer_tick = core_tick;

	// Toggles on each core tick; a half-rate square wave is the best one flop can give
	always_ff @(posedge aclk) begin
		if (!aresetn || ctrl.clock_output_disable) begin
			cycle_clock_output <= 1'b0;
		end else if (core_tick) begin
			cycle_clock_output <= !cycle_clock_output;
		end
	end

	// ==========================================================
	// Main sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= pcr_pkg::PCR_BOOT;
			div_code <= pcr_pkg::DIV_NONE;
			wake_cnt <= 14'h0000;
			power_down_ack <= 1'b0;
			context_restore <= 1'b0;
			context_clear_pulse <= 1'b0;
			boot_start <= 1'b0;
			boot_issued <= 1'b0;
			fetch_start <= 1'b0;
			fetch_addr <= pcr_pkg::FIRST_FETCH_ADDR;
		end else begin
			context_restore <= 1'b0;
			context_clear_pulse <= 1'b0;
			fetch_start <= 1'b0;
			case (state)
				pcr_pkg::PCR_BOOT: begin
					// Held while an external bus request is pending
					if (busreq_sync[1] == busreq_sync[2] && busreq_sync[2]) begin
						if (!boot_enable || (boot_issued && boot_done)) begin
							boot_start <= 1'b0;
							fetch_start <= 1'b1;
							fetch_addr <= pcr_pkg::FIRST_FETCH_ADDR;
							state <= pcr_pkg::PCR_RUN;
						end else if (!boot_issued) begin
							boot_start <= 1'b1;
							boot_issued <= 1'b1;
						end
					end
				end
				pcr_pkg::PCR_RUN: begin
					if (ctrl.commit && !pd_pending) begin
						state <= pcr_pkg::PCR_DORMANT;
						power_down_ack <= 1'b1;
					end else if (wr_go && wr_addr == pcr_pkg::IDLE_OFS && wr_strb[0]) begin
						div_code <= (wr_data[2:0] > pcr_pkg::DIV_128) ?
							pcr_pkg::DIV_NONE : wr_data[2:0];
						state <= pcr_pkg::PCR_IDLE;
					end
				end
				pcr_pkg::PCR_IDLE: begin
					// Wake is seen only on a core tick, up to divisor cycles late
					if ((wake_irq || pd_serviced) && core_tick) begin
						state <= pcr_pkg::PCR_RUN;
						div_code <= pcr_pkg::DIV_NONE;
					end
				end
				pcr_pkg::PCR_DORMANT: begin
					if (!sleep_level && !ctrl.sleep_force) begin
						power_down_ack <= 1'b0;
						wake_cnt <= ctrl.crystal_off ? CRYSTAL_LAST : RECOVER_LAST;
						state <= pcr_pkg::PCR_WAKE;
					end
				end
				pcr_pkg::PCR_WAKE: begin
					if (wake_cnt == 14'h0000) begin
						state <= pcr_pkg::PCR_RUN;
						if (ctrl.context_clear) begin
							context_clear_pulse <= 1'b1;
							fetch_start <= 1'b1;
							fetch_addr <= pcr_pkg::FIRST_FETCH_ADDR;
						end else begin
							context_restore <= 1'b1;
						end
					end else begin
						wake_cnt <= wake_cnt - 14'h0001;
					end
				end
				default: state <= pcr_pkg::PCR_BOOT;
			endcase
		end
	end

	// Later resets simply restart the sequencer; no clock wait is added
	assign stack_reset = !aresetn;
	assign dma_grant = (state == pcr_pkg::PCR_RUN || state == pcr_pkg::PCR_IDLE) ?
		dma_request : 3'h0;

	// ==========================================================
	// AXI4-Lite read path, one-cycle answer
	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= pcr_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= pcr_pkg::RESP_OKAY;
			case (s_axi_araddr)
				pcr_pkg::CTRL_OFS: s_axi_rdata <= {26'h0, ctrl};
				pcr_pkg::IDLE_OFS: s_axi_rdata <= {29'h0, div_code};
				pcr_pkg::STATUS_OFS: s_axi_rdata <= {25'h0, memory_mode, pd_pending,
					sleep_level, power_down_ack, state};
				pcr_pkg::MASK_OFS: s_axi_rdata <= 32'(irq_mask);
				pcr_pkg::MODE_STATUS_OFS: s_axi_rdata <= {16'h0, mode_status};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= pcr_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule // pcr_power_ctrl
`default_nettype wire
